// ### include/dtc_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the dual timer/counter
// Assumes: Registers sit at their printed offsets on a plain 8-bit address port
// Notes: Definitions only
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

`define DTC_OFS_MODE_CTRL 8'h89
`define DTC_OFS_T0_LOW 8'h8A
`define DTC_OFS_T1_LOW 8'h8B
`define DTC_OFS_T0_HIGH 8'h8C
`define DTC_OFS_T1_HIGH 8'h8D
`define DTC_OFS_RUN_FLAGS 8'h88
`define DTC_OFS_RATE_SEL 8'h8E

`define DTC_BIT_T1_GATE 7
`define DTC_BIT_T1_CSEL 6
`define DTC_BIT_T1_M1 5
`define DTC_BIT_T1_M0 4
`define DTC_BIT_T0_GATE 3
`define DTC_BIT_T0_CSEL 2
`define DTC_BIT_T0_M1 1
`define DTC_BIT_T0_M0 0

`define DTC_BIT_T1_FLAG 7
`define DTC_BIT_T1_RUN 6
`define DTC_BIT_T0_FLAG 5
`define DTC_BIT_T0_RUN 4

`define DTC_BIT_T1_RATE 4
`define DTC_BIT_T0_RATE 3

`define DTC_RST_BYTE 8'h00

`define DTC_CLK_HZ 25000000
`define DTC_DIV_SLOW 12
`define DTC_DIV_FAST 4
`define DTC_PRE_W 4

`endif

// ### include/dtc_pkg.sv
// Purpose: Types shared by the dual timer/counter
// Assumes: Constants come from dtc_defs.svh
// Notes: Mode encoding follows the two mode bits
package dtc_pkg;
   typedef enum logic [1:0] {
      DTC_MODE_13BIT = 2'b00,
      DTC_MODE_16BIT = 2'b01,
      DTC_MODE_RELOAD = 2'b10,
      DTC_MODE_SPLIT = 2'b11
   } dtc_mode_t;
   typedef logic [7:0] dtc_byte_t;
endpackage

// ### rtl/dtc_tick_gen.sv
// Purpose: Internal count-rate tick for one timer
// Assumes: Divides clk_i by 12 or by 4
// Notes: Free-running; a rate change moves the wrap point at once, so the current period may be cut short or stretched
`include "dtc_defs.svh"
module dtc_tick_gen (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Control
   input wire logic fast_i,
   // Tick
   output logic tick_o
);
   import dtc_pkg::*;
   logic [`DTC_PRE_W-1:0] cnt_q;
   logic [`DTC_PRE_W-1:0] last;

   assign last = fast_i ? `DTC_PRE_W'(`DTC_DIV_FAST - 1) : `DTC_PRE_W'(`DTC_DIV_SLOW - 1);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q <= '0;
         tick_o <= 1'b0;
      end else begin
         if (cnt_q >= last) begin
            cnt_q <= '0;
            tick_o <= 1'b1;
         end else begin
            cnt_q <= cnt_q + `DTC_PRE_W'(1);
            tick_o <= 1'b0;
         end
      end
   end
endmodule // dtc_tick_gen

// ### rtl/dtc_timer_pair.sv
// Purpose: Two 16-bit timer/counters with shared mode-control register
// Assumes: Register port with read data one cycle after the read strobe
// Notes: Count pins are sampled, so pin edges slower than 2 clocks are required
`include "dtc_defs.svh"
module dtc_timer_pair (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire dtc_pkg::dtc_byte_t wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output dtc_pkg::dtc_byte_t rdata_o,
   // Interrupt service acknowledge
   input wire logic t0_vector_i,
   input wire logic t1_vector_i,
   // Pins
   input wire logic ext_irq0_pin_i,
   input wire logic ext_irq1_pin_i,
   input wire logic count_input_pin_0_i,
   input wire logic count_input_pin_1_i,
   // Status
   output logic timer0_overflow_flag_o,
   output logic timer1_overflow_flag_o
);
   import dtc_pkg::*;

   dtc_byte_t timer_mode_control_q;
   dtc_byte_t timer0_low_byte_q;
   dtc_byte_t timer1_low_byte_q;
   dtc_byte_t timer0_high_byte_q;
   dtc_byte_t timer1_high_byte_q;
   logic timer0_run_q;
   logic timer1_run_q;
   logic timer0_flag_q;
   logic timer1_flag_q;
   logic timer0_rate_select_q;
   logic timer1_rate_select_q;

   // Pin synchronisers: index 0 irq0, 1 irq1, 2 count0, 3 count1
   logic [3:0] pin_raw;
   logic [3:0] s1_q;
   logic [3:0] s2_q;
   logic [3:0] s3_q;
   logic [3:0] pin_q;
   logic [3:0] pin_prev_q;
   logic [3:0] pin_fall;

   assign pin_raw = {count_input_pin_1_i, count_input_pin_0_i, ext_irq1_pin_i, ext_irq0_pin_i};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               s1_q[gi] <= 1'b0;
               s2_q[gi] <= 1'b0;
               s3_q[gi] <= 1'b0;
               pin_q[gi] <= 1'b0;
               pin_prev_q[gi] <= 1'b0;
            end else begin
               s1_q[gi] <= pin_raw[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               // Filtered level changes only when the two late stages agree
               if (s2_q[gi] == s3_q[gi]) begin
                  pin_q[gi] <= s3_q[gi];
               end
               pin_prev_q[gi] <= pin_q[gi];
            end
         end
         assign pin_fall[gi] = pin_prev_q[gi] & ~pin_q[gi];
      end
   endgenerate

   // Internal rate ticks
   logic tick0;
   logic tick1;

   dtc_tick_gen u_tick0 (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .fast_i(timer0_rate_select_q),
      .tick_o(tick0)
   );

   dtc_tick_gen u_tick1 (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .fast_i(timer1_rate_select_q),
      .tick_o(tick1)
   );

   // Mode-control fields
   dtc_mode_t mode0;
   dtc_mode_t mode1;
   logic gate0;
   logic gate1;
   logic csel0;
   logic csel1;

   assign mode1 = dtc_mode_t'(timer_mode_control_q[`DTC_BIT_T1_M1:`DTC_BIT_T1_M0]);
   assign mode0 = dtc_mode_t'(timer_mode_control_q[`DTC_BIT_T0_M1:`DTC_BIT_T0_M0]);
   assign gate1 = timer_mode_control_q[`DTC_BIT_T1_GATE];
   assign gate0 = timer_mode_control_q[`DTC_BIT_T0_GATE];
   assign csel1 = timer_mode_control_q[`DTC_BIT_T1_CSEL];
   assign csel0 = timer_mode_control_q[`DTC_BIT_T0_CSEL];

   // Enables and count events
   logic en0;
   logic en1;
   logic ev0;
   logic ev1;
   logic ev0_high;

   assign en0 = timer0_run_q & (~gate0 | pin_q[0]);
   assign en1 = timer1_run_q & (~gate1 | pin_q[1]);
   assign ev0 = en0 & (csel0 ? pin_fall[2] : tick0);
   assign ev1 = en1 & (csel1 ? pin_fall[3] : tick1) & (mode1 != DTC_MODE_SPLIT);
   // Split high byte borrows timer 1 run bit but always counts the internal rate
   assign ev0_high = timer1_run_q & tick0;

   // Next counts and overflows, one shared function called once per timer
   typedef struct packed {
      logic [7:0] low;
      logic [7:0] high;
      logic ovf;
      logic ovf_high;
   } dtc_step_t;

   function automatic dtc_step_t dtc_step(input dtc_mode_t mode, input dtc_byte_t lo,
                                          input dtc_byte_t hi, input logic ev, input logic ev_hi);
      dtc_step_t r;
      logic [5:0] lo5;
      logic [8:0] sum;
      r.low = lo;
      r.high = hi;
      r.ovf = 1'b0;
      r.ovf_high = 1'b0;
      lo5 = 6'h00;
      sum = 9'h000;
      case (mode)
         DTC_MODE_13BIT: begin
            if (ev) begin
               lo5 = {1'b0, lo[4:0]} + 6'h01;
               r.low = {lo[7:5], lo5[4:0]};
               if (lo5[5]) begin
                  sum = {1'b0, hi} + 9'h001;
                  r.high = sum[7:0];
                  r.ovf = sum[8];
               end
            end
         end
         DTC_MODE_16BIT: begin
            if (ev) begin
               {r.ovf, r.high, r.low} = {1'b0, hi, lo} + 17'h00001;
            end
         end
         DTC_MODE_RELOAD: begin
            if (ev) begin
               sum = {1'b0, lo} + 9'h001;
               r.low = sum[8] ? hi : sum[7:0];
               r.ovf = sum[8];
            end
         end
         DTC_MODE_SPLIT: begin
            if (ev) begin
               sum = {1'b0, lo} + 9'h001;
               r.low = sum[7:0];
               r.ovf = sum[8];
            end
            if (ev_hi) begin
               sum = {1'b0, hi} + 9'h001;
               r.high = sum[7:0];
               r.ovf_high = sum[8];
            end
         end
         default: begin
            r.low = lo;
         end
      endcase
      return r;
   endfunction

   dtc_step_t nx0;
   dtc_step_t nx1;
   logic set0;
   logic set1;

   assign nx0 = dtc_step(mode0, timer0_low_byte_q, timer0_high_byte_q, ev0,
                         ev0_high & (mode0 == DTC_MODE_SPLIT));
   assign nx1 = dtc_step(mode1, timer1_low_byte_q, timer1_high_byte_q, ev1, 1'b0);
   assign set0 = nx0.ovf;
   // In split mode timer 1 counts on without a flag unless its own mode is split too; the timer 0 high byte owns the timer 1 flag
   assign set1 = (mode0 == DTC_MODE_SPLIT) ? nx0.ovf_high : nx1.ovf;

   // Register writes
   logic wr_mode;
   logic wr_t0l;
   logic wr_t1l;
   logic wr_t0h;
   logic wr_t1h;
   logic wr_ctl;
   logic wr_rate;

   assign wr_mode = wr_i && (addr_i == `DTC_OFS_MODE_CTRL);
   assign wr_t0l = wr_i && (addr_i == `DTC_OFS_T0_LOW);
   assign wr_t1l = wr_i && (addr_i == `DTC_OFS_T1_LOW);
   assign wr_t0h = wr_i && (addr_i == `DTC_OFS_T0_HIGH);
   assign wr_t1h = wr_i && (addr_i == `DTC_OFS_T1_HIGH);
   assign wr_ctl = wr_i && (addr_i == `DTC_OFS_RUN_FLAGS);
   assign wr_rate = wr_i && (addr_i == `DTC_OFS_RATE_SEL);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timer_mode_control_q <= `DTC_RST_BYTE;
      end else if (wr_mode) begin
         timer_mode_control_q <= wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timer0_run_q <= 1'b0;
         timer1_run_q <= 1'b0;
      end else if (wr_ctl) begin
         timer0_run_q <= wdata_i[`DTC_BIT_T0_RUN];
         timer1_run_q <= wdata_i[`DTC_BIT_T1_RUN];
      end
   end

   // A rate change takes hold at once, so the tick in flight may come early or late
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timer0_rate_select_q <= 1'b0;
         timer1_rate_select_q <= 1'b0;
      end else if (wr_rate) begin
         timer0_rate_select_q <= wdata_i[`DTC_BIT_T0_RATE];
         timer1_rate_select_q <= wdata_i[`DTC_BIT_T1_RATE];
      end
   end

   // Software writes to a count byte win over the count in the same cycle
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timer0_low_byte_q <= `DTC_RST_BYTE;
      end else begin
         timer0_low_byte_q <= wr_t0l ? wdata_i : nx0.low;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timer0_high_byte_q <= `DTC_RST_BYTE;
      end else begin
         timer0_high_byte_q <= wr_t0h ? wdata_i : nx0.high;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timer1_low_byte_q <= `DTC_RST_BYTE;
      end else begin
         timer1_low_byte_q <= wr_t1l ? wdata_i : nx1.low;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timer1_high_byte_q <= `DTC_RST_BYTE;
      end else begin
         timer1_high_byte_q <= wr_t1h ? wdata_i : nx1.high;
      end
   end

   // Flags: hardware set beats any clear in the same cycle
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timer0_flag_q <= 1'b0;
      end else if (set0) begin
         timer0_flag_q <= 1'b1;
      end else if (wr_ctl) begin
         timer0_flag_q <= wdata_i[`DTC_BIT_T0_FLAG];
      end else if (t0_vector_i) begin
         timer0_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timer1_flag_q <= 1'b0;
      end else if (set1) begin
         timer1_flag_q <= 1'b1;
      end else if (wr_ctl) begin
         timer1_flag_q <= wdata_i[`DTC_BIT_T1_FLAG];
      end else if (t1_vector_i) begin
         timer1_flag_q <= 1'b0;
      end
   end

   assign timer0_overflow_flag_o = timer0_flag_q;
   assign timer1_overflow_flag_o = timer1_flag_q;

   // Read port
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= `DTC_RST_BYTE;
      end else if (rd_i) begin
         case (addr_i)
            `DTC_OFS_MODE_CTRL: rdata_o <= timer_mode_control_q;
            `DTC_OFS_T0_LOW: rdata_o <= timer0_low_byte_q;
            `DTC_OFS_T1_LOW: rdata_o <= timer1_low_byte_q;
            `DTC_OFS_T0_HIGH: rdata_o <= timer0_high_byte_q;
            `DTC_OFS_T1_HIGH: rdata_o <= timer1_high_byte_q;
            `DTC_OFS_RUN_FLAGS: rdata_o <= {timer1_flag_q, timer1_run_q, timer0_flag_q, timer0_run_q, 4'h0};
            `DTC_OFS_RATE_SEL: rdata_o <= {3'h0, timer1_rate_select_q, timer0_rate_select_q, 3'h0};
            default: rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end
endmodule // dtc_timer_pair

// ### verification/dtc_assertions.sv
// Purpose: Port checks of the timer pair
// Assumes: One clock domain
// Notes: Counting itself is judged by the bench
module dtc_checker (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire dtc_pkg::dtc_byte_t wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire dtc_pkg::dtc_byte_t rdata_o,
   // Vectors and flags
   input wire logic t0_vector_i,
   input wire logic t1_vector_i,
   input wire logic timer0_overflow_flag_o,
   input wire logic timer1_overflow_flag_o
);
   import dtc_pkg::*;
   logic set0, set1, clr0, clr1;
   // Flags may only drop for a vector or a software write of zero
   assign set0 = wr_i && addr_i == 8'h88 && wdata_i[5];
   assign set1 = wr_i && addr_i == 8'h88 && wdata_i[7];
   assign clr0 = t0_vector_i || (wr_i && addr_i == 8'h88 && !wdata_i[5]);
   assign clr1 = t1_vector_i || (wr_i && addr_i == 8'h88 && !wdata_i[7]);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);
   sequence s_wr(a);
      wr_i && addr_i == a;
   endsequence
   sequence s_rd(a);
      rd_i && addr_i == a;
   endsequence
   a_mode_readback: assert property (
      s_wr(8'h89) ##1 !wr_i ##1 s_rd(8'h89) |=> rdata_o == $past(wdata_i, 3)) else $error("mode readback");
   a_rate_readback: assert property (
      s_wr(8'h8E) ##1 !wr_i ##1 s_rd(8'h8E) |=> rdata_o == ($past(wdata_i, 3) & 8'h18)) else $error("rate readback");
   a_unmapped_zero: assert property (
      rd_i && (addr_i < 8'h88 || addr_i > 8'h8E) |=> rdata_o == 8'h00) else $error("unmapped read");
   a_run_low_zero: assert property (
      s_rd(8'h88) |=> rdata_o[3:0] == 4'h0) else $error("run byte low bits");
   a_flag0_fall: assert property (
      $fell(timer0_overflow_flag_o) |-> $past(clr0)) else $error("flag0 dropped");
   a_flag1_fall: assert property (
      $fell(timer1_overflow_flag_o) |-> $past(clr1)) else $error("flag1 dropped");
   a_flag0_set: assert property (
      set0 |=> timer0_overflow_flag_o) else $error("flag0 not set");
   a_flag1_set: assert property (
      set1 |=> timer1_overflow_flag_o) else $error("flag1 not set");
endmodule // dtc_checker

bind dtc_timer_pair dtc_checker u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .t0_vector_i(t0_vector_i), .t1_vector_i(t1_vector_i),
   .timer0_overflow_flag_o(timer0_overflow_flag_o), .timer1_overflow_flag_o(timer1_overflow_flag_o));

// ### verification/dtc_pin_model.sv
// Purpose: Gate and count pins of both timers
// Assumes: A pulse request lasts one clock
// Notes: Low for 4 clocks so the pin sampler cannot miss it
module dtc_pin_model (
   // Clock
   input wire logic clk_i,
   // Requests
   input wire logic [1:0] gate_i,
   input wire logic [1:0] pulse_i,
   // Pins
   output logic ext_irq0_pin_o,
   output logic ext_irq1_pin_o,
   output logic count_input_pin_0_o,
   output logic count_input_pin_1_o
);
   logic [3:0] low0_q = 4'h0;
   logic [3:0] low1_q = 4'h0;
   assign ext_irq0_pin_o = gate_i[0];
   assign ext_irq1_pin_o = gate_i[1];
   always @(posedge clk_i) begin
      low0_q <= pulse_i[0] ? 4'h4 : (low0_q != 4'h0 ? low0_q - 4'h1 : 4'h0);
      low1_q <= pulse_i[1] ? 4'h4 : (low1_q != 4'h0 ? low1_q - 4'h1 : 4'h0);
   end
   assign count_input_pin_0_o = (low0_q == 4'h0);
   assign count_input_pin_1_o = (low1_q == 4'h0);
endmodule // dtc_pin_model

// ### verification/test_dtc_timer_pair.sv
// Purpose: Register-level tests of the timer pair
// Assumes: Pin model stands on the pins
// Notes: Run windows are whole tick periods, so counts are exact
module test_dtc_timer_pair;
   timeunit 1ns;
   timeprecision 1ps;
   import dtc_pkg::*;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   dtc_byte_t wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic v0 = 1'b0;
   logic v1 = 1'b0;
   logic [1:0] gate = 2'b00;
   logic [1:0] pulse = 2'b00;
   dtc_byte_t rdata_o;
   logic irq0, irq1, cp0, cp1, f0, f1;
   int fails = 0;
   int cmp_count = 0;
   dtc_timer_pair dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .t0_vector_i(v0), .t1_vector_i(v1), .ext_irq0_pin_i(irq0),
      .ext_irq1_pin_i(irq1), .count_input_pin_0_i(cp0), .count_input_pin_1_i(cp1),
      .timer0_overflow_flag_o(f0), .timer1_overflow_flag_o(f1));
   dtc_pin_model pins (.clk_i(clk_i), .gate_i(gate), .pulse_i(pulse), .ext_irq0_pin_o(irq0),
      .ext_irq1_pin_o(irq1), .count_input_pin_0_o(cp0), .count_input_pin_1_o(cp1));
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   task automatic wrap_up();
      if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input dtc_byte_t d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input dtc_byte_t e);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      cmp_count++;
      if (rdata_o !== e) begin
         $display("unexpected reg %h: expected %h, seen %h", a, e, rdata_o);
         fails++;
      end
   endtask
   // Flags are looked at on the falling edge, away from the edge that sets them
   task automatic flg(input logic [1:0] e);
      @(negedge clk_i);
      cmp_count++;
      if ({f1, f0} !== e) begin
         $display("unexpected flags: expected %b, seen %b", e, {f1, f0});
         fails++;
      end
   endtask
   // Edges from start to stop equal m + 2
   task automatic run(input dtc_byte_t on, input dtc_byte_t off, input int m);
      wr(8'h88, on);
      repeat (m) @(posedge clk_i);
      wr(8'h88, off);
   endtask
   task automatic vec(input logic n);
      @(posedge clk_i);
      if (n) v1 <= 1'b1;
      else v0 <= 1'b1;
      @(posedge clk_i);
      v0 <= 1'b0;
      v1 <= 1'b0;
   endtask
   // Pin sampling needs some 5 clocks, so each pulse gets 14
   task automatic pul(input int k);
      repeat (k) begin
         @(posedge clk_i);
         pulse <= 2'b11;
         @(posedge clk_i);
         pulse <= 2'b00;
         repeat (12) @(posedge clk_i);
      end
   endtask
   initial begin
      repeat (6000) @(posedge clk_i);
      fails++;
      wrap_up();
   end
   initial begin
      repeat (5) @(posedge clk_i);
      arst_n_i <= 1'b1;
      for (int a = 8'h87; a <= 8'h8F; a++) rd(8'(a), 8'h00);
      wr(8'h89, 8'hA5);
      rd(8'h89, 8'hA5);
      wr(8'h8F, 8'hFF);
      rd(8'h8F, 8'h00);
      // Mode 1 at divide by 12: FFFE plus five ticks, wrapping at the second
      wr(8'h89, 8'h01);
      wr(8'h8A, 8'hFE);
      wr(8'h8C, 8'hFF);
      wr(8'h88, 8'h10);
      repeat (30) @(posedge clk_i);
      flg(2'b01);
      repeat (28) @(posedge clk_i);
      wr(8'h88, 8'h20);
      rd(8'h8A, 8'h03);
      rd(8'h8C, 8'h00);
      rd(8'h88, 8'h20);
      repeat (30) @(posedge clk_i);
      rd(8'h8A, 8'h03);
      vec(1'b0);
      flg(2'b00);
      rd(8'h88, 8'h00);
      // Mode 2 on timer 1 at divide by 4: reloads twice
      wr(8'h8E, 8'hFF);
      rd(8'h8E, 8'h18);
      wr(8'h89, 8'h20);
      wr(8'h8D, 8'hFD);
      wr(8'h8B, 8'hFE);
      run(8'h40, 8'h80, 18);
      flg(2'b10);
      rd(8'h8B, 8'hFD);
      rd(8'h8D, 8'hFD);
      vec(1'b1);
      rd(8'h88, 8'h00);
      // Mode 0: top three low bits stay as written; the wrap beats the clearing stop write
      wr(8'h89, 8'h00);
      wr(8'h8A, 8'hFE);
      wr(8'h8C, 8'hFF);
      run(8'h10, 8'h00, 6);
      flg(2'b01);
      rd(8'h8A, 8'hE0);
      rd(8'h8C, 8'h00);
      rd(8'h88, 8'h20);
      // Mode 3: timer 0 splits, timer 1 holds; both flags come from the wraps alone
      wr(8'h89, 8'h33);
      wr(8'h8A, 8'hFF);
      wr(8'h8C, 8'hFF);
      wr(8'h8B, 8'h12);
      run(8'h50, 8'h00, 2);
      flg(2'b11);
      rd(8'h8A, 8'h00);
      rd(8'h8C, 8'h00);
      rd(8'h8B, 8'h12);
      rd(8'h88, 8'hA0);
      // Pin falls counted, first gated shut, then open, then ungated
      wr(8'h89, 8'hDD);
      wr(8'h8A, 8'h00);
      wr(8'h8B, 8'h00);
      wr(8'h88, 8'h50);
      pul(3);
      rd(8'h8A, 8'h00);
      rd(8'h8B, 8'h00);
      @(posedge clk_i);
      gate <= 2'b11;
      repeat (8) @(posedge clk_i);
      pul(3);
      rd(8'h8A, 8'h03);
      rd(8'h8B, 8'h03);
      @(posedge clk_i);
      gate <= 2'b00;
      wr(8'h89, 8'h55);
      pul(2);
      rd(8'h8A, 8'h05);
      rd(8'h8B, 8'h05);
      wrap_up();
   end
endmodule // test_dtc_timer_pair
